// ==== src/pccard_pkg.sv ====
// Constants shared by the card-side host access decoder.
// Assumes an 8-bit local register port and a 10-bit card address bus.
package pccard_pkg;

  // Bus widths
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 8;
  localparam int IOBASE_W = 7;
  localparam int EMU_SEL  = 3;

  // Positions of the synchronised host inputs
  localparam int SYNC_W    = 7;
  localparam int SY_IORD   = 0;
  localparam int SY_IOWR   = 1;
  localparam int SY_WE     = 2;
  localparam int SY_OE     = 3;
  localparam int SY_CE     = 4;
  localparam int SY_REG    = 5;
  localparam int SY_RESET  = 6;

  // Host address bit that moves attribute accesses to the config space
  localparam int ADDR_CFG_BIT = 9;

  // Local register port map (byte offsets)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_IOBASE = 8'h01;
  localparam logic [7:0] REG_COR    = 8'h02;
  localparam logic [7:0] REG_EMUFLG = 8'h03;
  localparam logic [7:0] REG_EMU    = 8'h08;
  localparam logic [7:0] REG_ATTR   = 8'h40;

  // Field positions
  localparam int CTRL_READY = 0;
  localparam int CTRL_ANYIO = 1;
  localparam int COR_IOEN   = 0;

  // Reset values
  localparam logic [7:0]          CTRL_RST   = 8'h00;
  localparam logic [7:0]          COR_RST    = 8'h00;
  localparam logic [IOBASE_W-1:0] IOBASE_RST = 7'h00;
  // Synchroniser idle: strobes high (inactive), card reset stage low
  localparam logic [SYNC_W-1:0]   SYNC_IDLE  = 7'h3F;

endpackage

// ==== src/pc_card_host_access_decode.sv ====
// Card-side decode of host PC Card cycles: attribute memory,
// configuration option register and eight UART-emulation registers.
// Assumes host address/data are stable around the strobes; strobes are
// synchronised here. One local processor reaches the block over a plain port.
// Timing overview, one clock of 10 ns:
//   Every host strobe and the card reset pass two flip-flops (s1, s2)
//   before the decode acts on them. A strobe that goes low in
//   cycle c0 is therefore seen by the decode from cycle c2 on, and a
//   strobe that rises in cycle ck is seen inactive from cycle ck+2.
//
//   Attribute / configuration write:
//     c0      write strobe, card select and space select low
//     c0..    address and data are latched straight from the pins while
//             the live strobes are low, so the stored byte is the one
//             the host presented during the strobe
//     ck      host raises the write strobe or the card select
//     ck+2    synchronised decode drops; commit happens at this edge
//     ck+3    new value visible to reads
//   The commit is dropped without any indication when the card is not
//   configured for I/O and not ready.
//
//   Attribute / configuration read:
//     c2      data enable rises, first cycle still carries old data
//     c3      read data from the registered output stands
//   Hosts must hold the strobe for at least four cycles.
//
//   I/O read:
//     c2      input acknowledge low (in range, or answer-all mode)
//     c3      emulation register data stands
//   In answer-all mode an out-of-range read is acknowledged but the
//   data bus is not driven, so the host sees its own bus value.
//
//   I/O write (in range only):
//     committed two cycles after the write strobe rises and flags the
//     written emulation register for the local processor.
//
// Limitation: address and data are taken as synchronous to the clock;
// only the strobes are synchronised. A strobe shorter than one clock may
// be missed entirely by the decode.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module pc_card_host_access_decode #(
  parameter int ATTR_DEPTH = 32
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Host card bus
  input  wire logic [pccard_pkg::ADDR_W-1:0] card_addr_bus_i,
  input  wire logic [pccard_pkg::DATA_W-1:0] card_data_bus_i,
  output logic      [pccard_pkg::DATA_W-1:0] card_data_bus_o,
  output logic                               card_data_bus_oe_o,
  input  wire logic                          io_read_strobe_n_i,
  input  wire logic                          io_write_strobe_n_i,
  input  wire logic                          mem_write_strobe_n_i,
  input  wire logic                          mem_output_strobe_n_i,
  input  wire logic                          card_select_low_i,
  input  wire logic                          attr_space_select_n_i,
  input  wire logic                          card_reset_in_i,
  output logic                               input_ack_out_n_o,
  output logic                               ready_irq_line_o,
  // Local processor register port
  input  wire logic [7:0]                    cpu_addr_i,
  input  wire logic [7:0]                    cpu_wdata_i,
  input  wire logic                          cpu_wr_i,
  input  wire logic                          cpu_rd_i,
  output logic      [7:0]                    cpu_rdata_o
);

  localparam int AW = $clog2(ATTR_DEPTH);

  typedef struct packed {
    logic [pccard_pkg::SYNC_W-1:0]   s1;
    logic [pccard_pkg::SYNC_W-1:0]   s2;
    logic                            mw_prev;
    logic                            iw_prev;
    logic [pccard_pkg::ADDR_W-1:0]   lat_addr;
    logic [7:0]                      lat_data;
    logic [ATTR_DEPTH-1:0][7:0]      attr;
    logic [7:0][7:0]                 emu;
    logic [7:0]                      emu_flg;
    logic [7:0]                      cor;
    logic [7:0]                      ctrl;
    logic [pccard_pkg::IOBASE_W-1:0] io_base;
    logic [7:0]                      dout;
    logic [7:0]                      crd;
  } state_t;

  state_t r;
  state_t r_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the synchronised strobes

  logic          sel;
  logic          io_en;
  logic          io_hit;
  logic          mw_act;
  logic          mr_act;
  logic          ir_act;
  logic          iw_act;
  logic [AW-1:0] rd_idx;
  logic          rd_hit;
  logic [AW-1:0] wr_idx;
  logic          wr_hit;
  logic [AW-1:0] cpu_idx;
  logic          mw_raw;
  logic          iw_raw;

  // Only the second synchroniser stage is looked at
  assign sel    = ~r.s2[pccard_pkg::SY_CE] & ~r.s2[pccard_pkg::SY_REG];
  assign io_en  = r.cor[pccard_pkg::COR_IOEN];
  assign io_hit = card_addr_bus_i[9:3] == r.io_base;
  assign mw_act = sel & ~r.s2[pccard_pkg::SY_WE];
  assign mr_act = sel & ~r.s2[pccard_pkg::SY_OE];
  assign ir_act = sel & io_en & ~r.s2[pccard_pkg::SY_IORD];
  assign iw_act = sel & io_en & io_hit & ~r.s2[pccard_pkg::SY_IOWR];

  // Attribute bytes sit at even addresses; bit 0 is ignored
  assign rd_idx  = card_addr_bus_i[1 +: AW];
  assign rd_hit  = card_addr_bus_i[8:1] < 8'(ATTR_DEPTH);
  assign wr_idx  = r.lat_addr[1 +: AW];
  assign wr_hit  = r.lat_addr[8:1] < 8'(ATTR_DEPTH);
  assign cpu_idx = cpu_addr_i[AW-1:0];

  // Capture qualifiers taken straight from the pins. The synchronised
  // decode lags two cycles, so by the time it drops the host may already
  // have moved the data bus; latching on the live strobes keeps the byte
  // that stood while the strobe was low.
  assign mw_raw = ~mem_write_strobe_n_i & ~card_select_low_i & ~attr_space_select_n_i;
  assign iw_raw = ~io_write_strobe_n_i & ~card_select_low_i & ~attr_space_select_n_i &
                  io_en & io_hit;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    r_nxt = r;

    // Two-stage synchroniser for strobes and card reset
    r_nxt.s1 = {card_reset_in_i, attr_space_select_n_i, card_select_low_i,
                mem_output_strobe_n_i, mem_write_strobe_n_i,
                io_write_strobe_n_i, io_read_strobe_n_i};
    r_nxt.s2 = r.s1;

    // Keep the last address and data seen while a write strobe is low,
    // so the commit at the closing edge uses values from inside the cycle
    if (mw_raw || iw_raw) begin
      r_nxt.lat_addr = card_addr_bus_i;
      r_nxt.lat_data = card_data_bus_i;
    end
    r_nxt.mw_prev = mw_act;
    r_nxt.iw_prev = iw_act;

    // Local processor writes; host commits below override them
    if (cpu_wr_i) begin
      if (cpu_addr_i == pccard_pkg::REG_CTRL) begin
        r_nxt.ctrl = cpu_wdata_i;
      end else if (cpu_addr_i == pccard_pkg::REG_IOBASE) begin
        r_nxt.io_base = cpu_wdata_i[pccard_pkg::IOBASE_W-1:0];
      end else if (cpu_addr_i == pccard_pkg::REG_EMUFLG) begin
        r_nxt.emu_flg = r.emu_flg & ~cpu_wdata_i;
      end else if (cpu_addr_i[7:3] == pccard_pkg::REG_EMU[7:3]) begin
        r_nxt.emu[cpu_addr_i[2:0]] = cpu_wdata_i;
      end else if (cpu_addr_i[7:6] == pccard_pkg::REG_ATTR[7:6] &&
                   cpu_addr_i[5:0] < 6'(ATTR_DEPTH)) begin
        r_nxt.attr[cpu_idx] = cpu_wdata_i;
      end
    end

    // Attribute/config write closes when write strobe or select rises
    if (r.mw_prev && !mw_act &&
        (io_en || r.ctrl[pccard_pkg::CTRL_READY])) begin
      if (r.lat_addr[pccard_pkg::ADDR_CFG_BIT]) begin
        if (r.lat_addr[2:1] == 2'h0) begin
          r_nxt.cor = r.lat_data;
        end
      end else if (wr_hit) begin
        r_nxt.attr[wr_idx] = r.lat_data;
      end
    end

    // Emulation register write; the flag set wins over a clear
    if (r.iw_prev && !iw_act) begin
      r_nxt.emu[r.lat_addr[2:0]]     = r.lat_data;
      r_nxt.emu_flg[r.lat_addr[2:0]] = 1'b1;
    end

    // Card reset drops back to memory-only and busy
    if (r.s2[pccard_pkg::SY_RESET]) begin
      r_nxt.cor                        = pccard_pkg::COR_RST;
      r_nxt.ctrl[pccard_pkg::CTRL_READY] = 1'b0;
    end

    // Host read data, registered one cycle behind the decode
    if (mr_act) begin
      if (card_addr_bus_i[pccard_pkg::ADDR_CFG_BIT]) begin
        r_nxt.dout = (card_addr_bus_i[2:1] == 2'h0) ? r.cor : 8'h00;
      end else begin
        r_nxt.dout = rd_hit ? r.attr[rd_idx] : 8'h00;
      end
    end else begin
      r_nxt.dout = r.emu[card_addr_bus_i[2:0]];
    end

    // Local read data, valid in the cycle after the read strobe
    r_nxt.crd = 8'h00;
    if (cpu_rd_i) begin
      if (cpu_addr_i == pccard_pkg::REG_CTRL) begin
        r_nxt.crd = r.ctrl;
      end else if (cpu_addr_i == pccard_pkg::REG_IOBASE) begin
        r_nxt.crd = {1'b0, r.io_base};
      end else if (cpu_addr_i == pccard_pkg::REG_COR) begin
        r_nxt.crd = r.cor;
      end else if (cpu_addr_i == pccard_pkg::REG_EMUFLG) begin
        r_nxt.crd = r.emu_flg;
      end else if (cpu_addr_i[7:3] == pccard_pkg::REG_EMU[7:3]) begin
        r_nxt.crd = r.emu[cpu_addr_i[2:0]];
      end else if (cpu_addr_i[7:6] == pccard_pkg::REG_ATTR[7:6] &&
                   cpu_addr_i[5:0] < 6'(ATTR_DEPTH)) begin
        r_nxt.crd = r.attr[cpu_idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Synchroniser idles with strobes high and card reset low, so neither a
  // strobe nor a card reset looks active in the first cycles after reset;
  // a local write to the control register right after release must stick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r         <= '0;
      r.s1      <= pccard_pkg::SYNC_IDLE;
      r.s2      <= pccard_pkg::SYNC_IDLE;
      r.ctrl    <= pccard_pkg::CTRL_RST;
      r.cor     <= pccard_pkg::COR_RST;
      r.io_base <= pccard_pkg::IOBASE_RST;
    end else begin
      r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Acknowledge follows the synchronised read strobe, two cycles late
  assign input_ack_out_n_o  = ~(ir_act &
                                (io_hit | r.ctrl[pccard_pkg::CTRL_ANYIO]));
  assign card_data_bus_oe_o = mr_act | (ir_act & io_hit);
  assign card_data_bus_o    = r.dout;
  assign ready_irq_line_o   = r.ctrl[pccard_pkg::CTRL_READY];
  assign cpu_rdata_o        = r.crd;

endmodule // pc_card_host_access_decode

`default_nettype wire

// ==== verification/access_monitor.sv ====
// Checker bound to the card decoder top; sees its ports only.
// Assumes one clock; host strobes pass two flops before use.
`timescale 1ns/1ns
`default_nettype none
module access_monitor (
  // Host side, clock, reset and the local write strobe
  input wire logic       clk_i, rst_i, io_read_strobe_n_i, mem_output_strobe_n_i, card_select_low_i,
  input wire logic       attr_space_select_n_i, card_reset_in_i, input_ack_out_n_o, card_data_bus_oe_o,
  input wire logic       ready_irq_line_o, cpu_wr_i,
  // Local register port
  input wire logic [7:0] cpu_addr_i, cpu_wdata_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////
  // Outputs traced to inputs two edges back (ready to card reset: three), so a wrong sync depth shows
  a_ack_read: assert property (!input_ack_out_n_o |-> !$past(io_read_strobe_n_i, 2))
    else $error("stray ack");
  a_ack_select: assert property (!input_ack_out_n_o |-> !$past(card_select_low_i, 2))
    else $error("ack unselected");
  a_oe_select: assert property (card_data_bus_oe_o |-> !$past(card_select_low_i, 2))
    else $error("oe unselected");
  a_oe_space: assert property (card_data_bus_oe_o |-> !$past(attr_space_select_n_i, 2))
    else $error("oe without space");
  a_oe_strobe: assert property (card_data_bus_oe_o |->
    !$past(mem_output_strobe_n_i, 2) || !$past(io_read_strobe_n_i, 2)) else $error("oe without read");
  a_reset_idle: assert property ($fell(rst_i) |->
    !ready_irq_line_o && input_ack_out_n_o && !card_data_bus_oe_o) else $error("not idle");
  a_card_reset_busy: assert property ($past(card_reset_in_i, 3) |-> !ready_irq_line_o)
    else $error("ready in reset");
  a_ready_write: assert property (cpu_wr_i && cpu_addr_i == 8'h00 && !$past(card_reset_in_i, 2) |=>
    ready_irq_line_o == $past(cpu_wdata_i[0])) else $error("ready not set");
endmodule // access_monitor
bind pc_card_host_access_decode access_monitor i_access_monitor (.clk_i, .rst_i, .io_read_strobe_n_i,
  .mem_output_strobe_n_i, .card_select_low_i, .attr_space_select_n_i, .card_reset_in_i, .input_ack_out_n_o,
  .card_data_bus_oe_o, .ready_irq_line_o, .cpu_wr_i, .cpu_addr_i, .cpu_wdata_i);
`default_nettype wire

// ==== verification/host_model.sv ====
// Host socket adapter model: runs whole card cycles.
// Assumes the card answers a read within five cycles.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_i,
  input  wire logic       ack_n_i,
  output logic      [9:0] addr_o,
  output logic      [7:0] data_o,
  output logic      [5:0] strb_n_o
);
  // Strobe order {space, select, io read, io write, output, write}
  initial strb_n_o = 6'h3F;
  initial {addr_o, data_o} = 18'h0;
  // Kind 0..3: memory write, memory read, io write, io read
  task automatic cyc(input int k, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q, output logic ack);
    @(posedge clk_i);
    addr_o   <= a;
    data_o   <= d;
    strb_n_o <= ~(6'h30 | 6'(1 << k));
    repeat (5) @(posedge clk_i);
    q        = bus_i;
    ack      = ack_n_i;
    strb_n_o <= 6'h3F;
    data_o   <= ~d; // Released bus must not keep the old byte
    repeat (4) @(posedge clk_i);
  endtask
endmodule // host_model
`default_nettype wire

// ==== verification/pc_card_host_access_decode_tb.sv ====
// Self-checking bench for the card host access decoder.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pc_card_host_access_decode_tb;
  logic       clk_i = 1'h0;
  logic       rst_i, crst, cwr, crd, a, ack_n, oe, rdy;
  logic [7:0] caddr, cwd, crdata, hdo, hd, d, q;
  logic [9:0] haddr;
  logic [6:0] b;
  logic [5:0] strb;
  int         failures, n_checks, seed;
  // Shared data wire: the card wins while it drives
  wire logic [7:0] bus = oe ? hdo : hd;
  pc_card_host_access_decode i_pc_card_host_access_decode (.clk_i, .rst_i, .card_addr_bus_i(haddr),
    .card_data_bus_i(bus), .card_data_bus_o(hdo), .card_data_bus_oe_o(oe), .io_read_strobe_n_i(strb[3]),
    .io_write_strobe_n_i(strb[2]), .mem_write_strobe_n_i(strb[0]), .mem_output_strobe_n_i(strb[1]),
    .card_select_low_i(strb[4]), .attr_space_select_n_i(strb[5]), .card_reset_in_i(crst),
    .input_ack_out_n_o(ack_n), .ready_irq_line_o(rdy), .cpu_addr_i(caddr), .cpu_wdata_i(cwd),
    .cpu_wr_i(cwr), .cpu_rd_i(crd), .cpu_rdata_o(crdata));
  host_model i_host_model (.clk_i, .bus_i(bus), .ack_n_i(ack_n), .addr_o(haddr), .data_o(hd), .strb_n_o(strb));
  // 100 MHz clock
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One local access; read data is looked at in the one cycle it stands
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk_i);
    caddr      <= ad;
    cwd        <= v;
    {cwr, crd} <= {w, !w};
    @(posedge clk_i);
    {cwr, crd} <= 2'h0;
    #1 if (!w) chk("cpu_rdata", crdata, v);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset, then corner cases with random data
  initial begin
    seed = 32'hC67F;
    {rst_i, crst, cwr, crd, caddr, cwd} = {4'h8, 16'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1'h0, 8'h02, 8'h00);
    chk("ready_rst", 8'(rdy), 8'h00);
    d = 8'($random(seed));
    i_host_model.cyc(0, 10'h004, d, q, a);
    acc(1'h0, 8'h42, 8'h00);
    acc(1'h1, 8'h00, 8'h01);
    chk("ready_set", 8'(rdy), 8'h01);
    i_host_model.cyc(0, 10'h004, d, q, a);
    acc(1'h0, 8'h42, d);
    i_host_model.cyc(1, 10'h004, 8'h00, q, a);
    chk("attr_read", q, d);
    i_host_model.cyc(0, 10'h200, 8'h01, q, a);
    acc(1'h0, 8'h02, 8'h01);
    b = 7'($random(seed));
    acc(1'h1, 8'h01, {1'h0, b});
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      i_host_model.cyc(2, {b, 3'(i)}, d, q, a);
      acc(1'h0, 8'h08 + 8'(i), d);
      i_host_model.cyc(3, {b, 3'(i)}, 8'h00, q, a);
      chk("io_read", q, d);
      chk("ack_in", 8'(a), 8'h00);
    end
    i_host_model.cyc(3, {~b, 3'h0}, 8'h00, q, a);
    chk("ack_out", 8'(a), 8'h01);
    acc(1'h1, 8'h00, 8'h03);
    i_host_model.cyc(3, {~b, 3'h0}, 8'h00, q, a);
    chk("ack_any", 8'(a), 8'h00);
    crst <= 1'h1;
    repeat (3) @(posedge clk_i);
    crst <= 1'h0;
    repeat (3) @(posedge clk_i);
    acc(1'h0, 8'h02, 8'h00);
    chk("ready_crst", 8'(rdy), 8'h00);
    end_of_test();
  end
endmodule // pc_card_host_access_decode_tb
`default_nettype wire
